//--- hdl/pcl_pin_control.sv
// pin control logic: fetch steering, reset pin, interrupts, counters, bus
// Operation
// - strap low: every program fetch goes off-chip.
// - strap high: fetch on-chip inside on-chip range, else off-chip.
// - strap is captured during reset; later pin changes are ignored.
// - edge select set: falling edge sets the interrupt pending flag.
// - edge select clear: low level sets the interrupt pending flag.
// - reset pin held high 64 oscillator periods gives full reset.
// - port pins go to reset state as soon as reset pin asserts.
// - reset pin ends idle and powerdown, back to normal operation.
// - counter mode: each falling edge of event input bumps count.
// - fetch strobe only for external accesses in selected range.
// - range bits pick read strobe or address bit 16 on shared pin.
// - page mode: low port low address; high port address and data.
// - nonpage mode: low port muxes address and data; high port address.
// - external clock input may drive the 16-bit counter array.
// - receive pin sends and receives in mode 0, receives otherwise.
// - transmit pin gives shift clock in mode 0, data otherwise.
`timescale 1ns/1ns
module pcl_pin_control
  import pcl_pkg::*;
#(
  parameter int ONCHIP_CODE_BYTES = 32768
) (
  input  wire logic        clk,                      // 100 MHz clock
  input  wire logic        reset,                    // sync, active high
  input  wire logic        reset_pin,                // raw reset input
  input  wire logic        external_fetch_strap,     // raw strap pin
  input  wire logic [1:0]  external_interrupt_inputs, // raw, low active
  input  wire logic [1:0]  counter_event_inputs,     // raw event pins
  input  wire logic        counter_array_external_clock, // raw clock pin
  input  wire logic [1:0]  interrupt_edge_select_bits, // 1 edge, 0 level
  input  wire logic [1:0]  interrupt_flag_clear,     // clear pending flag
  input  wire logic [1:0]  counter_mode_bits,        // 1 counts events
  input  wire logic        counter_array_run,        // counter array on
  input  wire logic        counter_array_ext_select, // count ext clock
  input  wire logic        fetch_range_bit_low,      // range code bit 0
  input  wire logic        fetch_range_bit_high,     // range code bit 1
  input  wire logic        page_mode,                // 1 page bus mode
  input  wire logic        enter_idle,               // pulse into idle
  input  wire logic        enter_powerdown,          // pulse into powerdown
  input  pcl_bus_req_type  bus_req,                  // access request
  output pcl_bus_ans_type  bus_ans,                  // access answer
  output logic             bus_busy,                 // external cycle on
  input  wire logic [7:0]  low_port_pins_in,         // raw low port
  input  wire logic [7:0]  high_port_pins_in,        // raw high port
  output pcl_port_type     low_port_pins,            // low port drive
  output pcl_port_type     high_port_pins,           // high port drive
  output logic             program_fetch_strobe_n,   // fetch strobe
  output logic             read_or_a16_out,          // read strobe or A16
  output logic             write_strobe_n,           // write strobe
  input  wire logic [1:0]  serial_mode,              // serial port mode
  input  wire logic        serial_shift_clock,       // mode 0 shift clock
  input  wire logic        serial_tx_data,           // serial data out
  input  wire logic        serial_rx_drive,          // mode 0 send phase
  input  wire logic        receive_data_in,          // raw receive pin
  output logic             receive_data_out,         // receive pin drive
  output logic             receive_data_oe,          // receive pin enable
  output logic             transmit_data_out,        // transmit pin
  output logic             serial_rx_data,           // synchronised rx
  output logic [1:0]       external_interrupt_pending_flags, // flags
  output logic [1:0][15:0] timer_counts,             // event counts
  output logic [15:0]      counter_array_count,      // counter array
  output logic             chip_reset,               // internal reset
  output logic             idle_active,              // idle mode
  output logic             powerdown_active,         // powerdown mode
  output logic             fetch_strap_latched       // captured strap
);
  logic [SYNC_W-1:0]    pin_level;
  logic [SYNC_W-1:0]    pin_fall;
  logic [15:0]          port_level;
  logic                 rst_level;
  logic [HOLD_W-1:0]    hold_count;
  logic [RELEASE_W-1:0] release_count;
  logic                 pins_reset;
  logic                 take;
  logic                 external;
  logic                 last_data;
  logic                 rd_role;
  logic                 program_fetch_strobe_hit;
  logic [1:0]           range_code;
  pcl_bus_state_type    state;
  pcl_bus_state_type    next_state;
  pcl_bus_req_type      req_q;
  pcl_bus_req_type      cur_req;
  logic [PHASE_W-1:0]   phase_count;

  pcl_pin_sync #(
    .WIDTH       (SYNC_W),
    .RESET_LEVEL (SYNC_RESET)
  ) u_pin_sync (
    .clk   (clk),
    .reset (reset),
    .pins  ({receive_data_in, external_fetch_strap, reset_pin,
             counter_array_external_clock, counter_event_inputs,
             external_interrupt_inputs}),
    .level (pin_level),
    .fall  (pin_fall)
  );

  pcl_pin_sync #(
    .WIDTH       (16),
    .RESET_LEVEL (PORT_SYNC_RESET)
  ) u_port_sync (
    .clk   (clk),
    .reset (reset),
    .pins  ({high_port_pins_in, low_port_pins_in}),
    .level (port_level),
    .fall  ()
  );

  assign rst_level      = pin_level[IDX_RST];
  assign pins_reset     = rst_level | chip_reset;
  assign serial_rx_data = pin_level[IDX_RXD];

  always_ff @(posedge clk) begin
    if (reset || !rst_level) begin
      hold_count <= '0;
    end else if (hold_count != HOLD_W'(RESET_HOLD_CYCLES)) begin
      hold_count <= hold_count + HOLD_W'(1);
    end
  end

  // leaving reset waits a few low samples so the strap has settled; the
  // strap needs four edges through its synchroniser after a reset, so the
  // release waits for the saturated count, one edge past that
  always_ff @(posedge clk) begin
    if (reset || !chip_reset || rst_level) begin
      release_count <= '0;
    end else if (release_count != RELEASE_W'(RELEASE_CYCLES)) begin
      release_count <= release_count + RELEASE_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chip_reset <= 1'b1;
    end else if (rst_level &&
                 hold_count == HOLD_W'(RESET_HOLD_CYCLES - 1)) begin
      chip_reset <= 1'b1;
    end else if (!rst_level &&
                 release_count == RELEASE_W'(RELEASE_CYCLES)) begin
      chip_reset <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_strap_latched <= STRAP_OFFCHIP_ONLY;
    end else if (chip_reset) begin
      fetch_strap_latched <= pin_level[IDX_STRAP];
    end
  end

  // wake from low power
  // a stopped oscillator is outside this model: wake needs clk running
  always_ff @(posedge clk) begin
    if (reset || pins_reset) begin
      idle_active      <= 1'b0;
      powerdown_active <= 1'b0;
    end else begin
      if (enter_idle) begin
        idle_active <= 1'b1;
      end
      if (enter_powerdown) begin
        powerdown_active <= 1'b1;
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset || chip_reset) begin
      external_interrupt_pending_flags <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (interrupt_edge_select_bits[i] ? pin_fall[IDX_INT + i]
                                          : !pin_level[IDX_INT + i]) begin
          external_interrupt_pending_flags[i] <= 1'b1;
        end else if (interrupt_flag_clear[i]) begin
          external_interrupt_pending_flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || chip_reset) begin
      timer_counts <= {COUNT_RESET, COUNT_RESET};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (counter_mode_bits[i] && pin_fall[IDX_CNT + i]) begin
          timer_counts[i] <= timer_counts[i] + COUNT_STEP;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || chip_reset) begin
      counter_array_count <= COUNT_RESET;
    end else if (counter_array_run &&
                 (!counter_array_ext_select || pin_fall[IDX_ECI])) begin
      counter_array_count <= counter_array_count + COUNT_STEP;
    end
  end

  // size zero models a part whose strap the board ties low
  assign external = !bus_req.fetch ||
                    fetch_strap_latched == STRAP_OFFCHIP_ONLY ||
                    bus_req.addr >= ADDR_W'(ONCHIP_CODE_BYTES);
  assign take      = bus_req.valid && state == BUS_IDLE && !pins_reset;
  assign last_data = phase_count == PHASE_W'(DATA_CYCLES - 1);
  assign cur_req   = (state == BUS_IDLE) ? bus_req : req_q;

  always_comb begin
    next_state = state;
    unique case (state)
      BUS_IDLE: if (take && external) next_state = BUS_ADDR;
      BUS_ADDR: next_state = BUS_DATA;
      BUS_DATA: if (last_data) next_state = BUS_IDLE;
      default:  next_state = BUS_IDLE;
    endcase
    if (pins_reset) begin
      next_state = BUS_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state != BUS_DATA) begin
      phase_count <= '0;
    end else begin
      phase_count <= phase_count + PHASE_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      req_q <= '0;
    end else if (take) begin
      req_q <= bus_req;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_busy <= 1'b0;
    end else begin
      bus_busy <= next_state != BUS_IDLE;
    end
  end

  // read data comes back on whichever port carries data in this mode
  always_ff @(posedge clk) begin
    if (reset || pins_reset) begin
      bus_ans <= '0;
    end else if (take && !external) begin
      bus_ans <= '{done: 1'b1, onchip: 1'b1, rdata: '0};
    end else if (state == BUS_DATA && last_data) begin
      bus_ans.done   <= 1'b1;
      bus_ans.onchip <= 1'b0;
      if (!req_q.write) begin
        bus_ans.rdata <= page_mode ? port_level[15:8] : port_level[7:0];
      end
    end else begin
      bus_ans.done <= 1'b0;
    end
  end

  assign range_code = {fetch_range_bit_high, fetch_range_bit_low};
  assign rd_role    = fetch_range_bit_high;
  assign program_fetch_strobe_hit   = cur_req.fetch || !rd_role ||
                      (range_code == RANGE_SPLIT && cur_req.addr[ADDR_A16]);

  always_ff @(posedge clk) begin
    if (reset || pins_reset) begin
      program_fetch_strobe_n <= 1'b1;
      read_or_a16_out        <= 1'b1;
      write_strobe_n         <= 1'b1;
    end else begin
      program_fetch_strobe_n <= !(next_state == BUS_DATA &&
                                  !cur_req.write && program_fetch_strobe_hit);
      write_strobe_n         <= !(next_state == BUS_DATA && cur_req.write);
      if (rd_role) begin
        read_or_a16_out <= !(next_state == BUS_DATA &&
                             !cur_req.write && !program_fetch_strobe_hit);
      end else if (next_state != BUS_IDLE) begin
        read_or_a16_out <= cur_req.addr[ADDR_A16];
      end else begin
        read_or_a16_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || pins_reset || next_state == BUS_IDLE) begin
      low_port_pins  <= '{out: PORT_RESET, oe: OE_OFF};
      high_port_pins <= '{out: PORT_RESET, oe: OE_OFF};
    end else if (next_state == BUS_ADDR) begin
      low_port_pins  <= '{out: cur_req.addr[7:0],  oe: OE_ALL};
      high_port_pins <= '{out: cur_req.addr[15:8], oe: OE_ALL};
    end else if (page_mode) begin
      low_port_pins  <= '{out: cur_req.addr[7:0], oe: OE_ALL};
      high_port_pins <= '{out: cur_req.wdata,
                          oe: cur_req.write ? OE_ALL : OE_OFF};
    end else begin
      low_port_pins  <= '{out: cur_req.wdata,
                          oe: cur_req.write ? OE_ALL : OE_OFF};
      high_port_pins <= '{out: cur_req.addr[15:8], oe: OE_ALL};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || pins_reset) begin
      receive_data_out  <= 1'b1;
      receive_data_oe   <= 1'b0;
      transmit_data_out <= 1'b1;
    end else begin
      receive_data_out  <= serial_tx_data;
      receive_data_oe   <= serial_mode == SERIAL_MODE0 && serial_rx_drive;
      transmit_data_out <= (serial_mode == SERIAL_MODE0) ?
                           serial_shift_clock : serial_tx_data;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  strap_hold_a: assert property (
    !chip_reset && !$past(chip_reset) |-> $stable(fetch_strap_latched))
    else $error("strap value changed outside reset");
  offchip_only_a: assert property (
    take && fetch_strap_latched == STRAP_OFFCHIP_ONLY
      |=> state == BUS_ADDR ##1 state == BUS_DATA)
    else $error("fetch not sent off-chip with strap low");
  onchip_fetch_a: assert property (
    take && bus_req.fetch && fetch_strap_latched &&
    bus_req.addr < ADDR_W'(ONCHIP_CODE_BYTES)
      |=> bus_ans.done && bus_ans.onchip && state == BUS_IDLE)
    else $error("on-chip fetch left the chip");
  edge_flag_a: assert property (
    !chip_reset && interrupt_edge_select_bits[0] && pin_fall[IDX_INT]
      |=> external_interrupt_pending_flags[0])
    else $error("falling edge did not set pending flag");
  level_flag_a: assert property (
    !chip_reset && !interrupt_edge_select_bits[1] &&
    !pin_level[IDX_INT + 1] |=> external_interrupt_pending_flags[1])
    else $error("low level did not set pending flag");
  reset_count_a: assert property (
    $rose(chip_reset) |-> $past(hold_count) ==
                          HOLD_W'(RESET_HOLD_CYCLES - 1))
    else $error("reset started before full high count");
  port_reset_a: assert property (
    rst_level |=> low_port_pins.oe == OE_OFF && high_port_pins.oe == OE_OFF
                  && program_fetch_strobe_n)
    else $error("ports not in reset state under reset pin");
  wake_up_a: assert property (
    rst_level |=> !idle_active && !powerdown_active)
    else $error("reset pin did not end low power mode");
  event_count_a: assert property (
    !chip_reset && counter_mode_bits[0] && pin_fall[IDX_CNT]
      |=> timer_counts[0] == $past(timer_counts[0]) + COUNT_STEP)
    else $error("event edge not counted");
  fetch_strobe_a: assert property (
    state == BUS_DATA && req_q.fetch && !req_q.write
      |-> !program_fetch_strobe_n && write_strobe_n)
    else $error("fetch strobe missing in fetch data phase");
  page_port_a: assert property (
    state == BUS_DATA && page_mode && $past(page_mode)
      |-> low_port_pins.out == req_q.addr[7:0])
    else $error("page mode low port lost the address");
  shift_clock_a: assert property (
    serial_mode == SERIAL_MODE0 && !pins_reset
      |=> transmit_data_out == $past(serial_shift_clock))
    else $error("transmit pin not carrying shift clock");
endmodule

//--- hdl/pcl_pkg.sv
// shared constants and types for the pin control logic
package pcl_pkg;

  // external bus
  localparam int ADDR_W            = 18;
  localparam int ADDR_A16          = 16;
  localparam int DATA_W            = 8;
  localparam int DATA_CYCLES       = 6;
  localparam int PHASE_W           = $clog2(DATA_CYCLES);
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [7:0] OE_OFF     = 8'h00;
  localparam logic [7:0] OE_ALL     = 8'hFF;

  // fetch steering
  localparam logic STRAP_OFFCHIP_ONLY = 1'b0;
  localparam logic [1:0] RANGE_SPLIT  = 2'h2;

  // reset pin timing: periods of the oscillator, converted to clk cycles
  localparam int CLK_PERIOD_NS      = 10;
  localparam int OSC_PERIOD_NS      = 10;
  localparam int RESET_HOLD_PERIODS = 64;
  localparam int RESET_HOLD_CYCLES  =
    (RESET_HOLD_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W             = $clog2(RESET_HOLD_CYCLES + 1);
  localparam int RELEASE_CYCLES     = 4;
  localparam int RELEASE_W          = $clog2(RELEASE_CYCLES + 1);

  // counters
  localparam int COUNT_W                = 16;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_STEP    = 16'h0001;

  // serial pins
  localparam logic [1:0] SERIAL_MODE0 = 2'h0;

  // positions inside the synchronised pin vector
  localparam int IDX_INT   = 0;
  localparam int IDX_CNT   = 2;
  localparam int IDX_ECI   = 4;
  localparam int IDX_RST   = 5;
  localparam int IDX_STRAP = 6;
  localparam int IDX_RXD   = 7;
  localparam int SYNC_W    = 8;
  localparam logic [7:0]  SYNC_RESET      = 8'hDF;
  localparam logic [15:0] PORT_SYNC_RESET = 16'hFFFF;

  typedef struct packed {
    logic              valid;
    logic              fetch;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcl_bus_req_type;

  typedef struct packed {
    logic              done;
    logic              onchip;
    logic [DATA_W-1:0] rdata;
  } pcl_bus_ans_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pcl_port_type;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ADDR = 3'b010,
    BUS_DATA = 3'b100
  } pcl_bus_state_type;

endpackage

//--- hdl/pcl_pin_sync.sv
// three-stage pin synchroniser with agreed level and falling-edge pulse
`timescale 1ns/1ns
module pcl_pin_sync #(
  parameter int               WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
  input  wire logic             clk,   // system clock
  input  wire logic             reset, // synchronous, active high
  input  wire logic [WIDTH-1:0] pins,  // raw asynchronous pins
  output logic      [WIDTH-1:0] level, // agreed level
  output logic      [WIDTH-1:0] fall   // one-cycle pulse per high-to-low
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // sync and compare
  // a bit only moves once stages two and three agree, so a pin that
  // glitches for a single sample never reaches the flags or counters
  always_ff @(posedge clk) begin
    if (reset) begin
      level <= RESET_LEVEL;
      fall  <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
          fall[i]  <= level[i] & ~s3[i];
        end else begin
          fall[i]  <= 1'b0;
        end
      end
    end
  end
endmodule

//--- verification/pcl_ext_memory.sv
// external memory and board pull-ups facing the bus pins
`timescale 1ns/1ns
module pcl_ext_memory
  import pcl_pkg::*;
(
  input  wire pcl_port_type low_port,     // low port drive
  input  wire pcl_port_type high_port,    // high port drive
  input  wire logic         clk,          // system clock
  input  wire logic         fetch_n,      // fetch strobe
  input  wire logic         rd_pin,       // read strobe or address bit 16
  input  wire logic         rd_is_strobe, // range code picks read strobe
  input  wire logic         wr_n,         // write strobe
  input  wire logic         page,         // page bus mode
  output logic [7:0]        low_in,       // low port wire level
  output logic [7:0]        high_in,      // high port wire level
  output logic [7:0]        last_wdata    // last byte written
);
  logic [15:0] addr;
  logic [7:0]  dat;
  logic        rd_on;
  initial begin
    {low_in, high_in, last_wdata} = 24'hFFFF00;
    addr = 16'h0000;
    forever begin
      @(posedge clk);
      #1;
      rd_on = !fetch_n || (rd_is_strobe && !rd_pin);
      if (low_port.oe == OE_ALL && fetch_n && wr_n && !rd_on)
        addr = {high_port.out, low_port.out};
      if (!wr_n)
        last_wdata = page ? high_port.out : low_port.out;
      dat = addr[7:0] ^ addr[15:8] ^ 8'hA5;
      // high port has pull-ups; the open-drain low port floats when released
      high_in = high_port.oe == OE_ALL ? high_port.out
              : (page && rd_on ? dat : 8'hFF);
      low_in = low_port.oe == OE_ALL ? low_port.out
             : (!page && rd_on ? dat : ~low_in);
    end
  end
endmodule

//--- verification/pcl_pin_control_tb.sv
// self-checking bench for the pin control logic
`timescale 1ns/1ns
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  n_fail++; $display("BAD %s exp %h got %h", n, e, a); end end
module pcl_pin_control_tb
  import pcl_pkg::*;
;
  logic clk, reset, reset_pin, external_fetch_strap, page_mode, enter_idle;
  logic counter_array_external_clock, counter_array_run, bus_busy;
  logic counter_array_ext_select, fetch_range_bit_low, fetch_range_bit_high;
  logic enter_powerdown, serial_shift_clock, serial_tx_data, serial_rx_drive;
  logic receive_data_in, receive_data_out, receive_data_oe, transmit_data_out;
  logic serial_rx_data, chip_reset, idle_active, powerdown_active, rd_low;
  logic program_fetch_strobe_n, read_or_a16_out, write_strobe_n, ps_seen;
  logic fetch_strap_latched;
  logic [1:0] external_interrupt_inputs, counter_event_inputs, serial_mode;
  logic [1:0] interrupt_edge_select_bits, interrupt_flag_clear;
  logic [1:0] counter_mode_bits, external_interrupt_pending_flags;
  logic [1:0][15:0] timer_counts;
  logic [15:0] counter_array_count;
  logic [7:0] low_port_pins_in, high_port_pins_in, wdat;
  pcl_bus_req_type bus_req;
  pcl_bus_ans_type bus_ans;
  pcl_port_type low_port_pins, high_port_pins;
  int n_fail, check_count;
  pcl_pin_control uut (.*);
  pcl_ext_memory mem (.clk(clk), .low_port(low_port_pins),
    .high_port(high_port_pins), .fetch_n(program_fetch_strobe_n),
    .rd_pin(read_or_a16_out), .rd_is_strobe(fetch_range_bit_high),
    .wr_n(write_strobe_n), .page(page_mode), .low_in(low_port_pins_in),
    .high_in(high_port_pins_in), .last_wdata(wdat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrel();
    for (int i = 0; i < 40 && chip_reset !== 1'b0; i++) step(1);
    `CHK("chip_reset", 1'b0, chip_reset)
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one access; lat is the take-to-done distance, 1 means on-chip
  task automatic acc(input logic f, w, input logic [17:0] a,
                     input logic [7:0] d, input int lat);
    int i;
    bus_req = '{1'b1, f, w, a, d};
    step(1);
    bus_req.valid = 1'b0;
    {ps_seen, rd_low} = 2'b00;
    for (i = 0; i < 20 && bus_ans.done !== 1'b1; i++) begin
      step(1);
      ps_seen |= bus_busy & !program_fetch_strobe_n;
      rd_low |= bus_busy & !read_or_a16_out;
    end
    `CHK("latency", lat, i + 1)
    `CHK("onchip", lat == 1, bus_ans.onchip)
    if (!w) `CHK("rdata", lat == 1 ? 8'h00 : a[7:0] ^ a[15:8] ^ 8'hA5,
                  bus_ans.rdata)
  endtask
  task automatic t_fetch();
    acc(1'b1, 1'b0, 18'h00100, 8'h00, 1);
    acc(1'b1, 1'b0, 18'h08000, 8'h00, 8);
    external_fetch_strap = 1'b0;
    step(8);
    acc(1'b1, 1'b0, 18'h07FFF, 8'h00, 1);
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    wrel();
    acc(1'b1, 1'b0, 18'h00010, 8'h00, 8);
    `CHK("strap", STRAP_OFFCHIP_ONLY, fetch_strap_latched)
  endtask
  task automatic t_range();
    for (int k = 0; k < 4; k++) begin
      {fetch_range_bit_high, fetch_range_bit_low} =
        k == 0 ? 2'h0 : (k == 1 ? 2'h3 : RANGE_SPLIT);
      acc(1'b0, 1'b0, {1'b0, ~k[0], 16'h0040}, 8'h00, 8);
      `CHK("fetch strobe", !k[0], ps_seen)
      `CHK("read pin low", k[0], rd_low)
    end
  endtask
  task automatic t_bus();
    for (int p = 0; p < 2; p++) begin
      page_mode = p[0];
      acc(1'b0, 1'b1, 18'h01234, 8'hC3 ^ p[7:0], 8);
      `CHK("write data", 8'hC3 ^ p[7:0], wdat)
      acc(1'b0, 1'b0, 18'h0ABCD, 8'h00, 8);
    end
    page_mode = 1'b0;
  endtask
  task automatic t_int();
    interrupt_edge_select_bits = 2'h1;
    for (int s = 0; s < 3; s++) begin
      external_interrupt_inputs = s == 0 ? 2'h2 : (s == 1 ? 2'h0 : 2'h3);
      step(8);
      if (s == 0)
        `CHK("edge set", 1'b1, external_interrupt_pending_flags[0])
      interrupt_flag_clear = 2'h3;
      step(1);
      interrupt_flag_clear = 2'h0;
      // edge flag stays clear while held low; level flag keeps re-setting
      `CHK("flags", s == 1 ? 2'h2 : 2'h0,
           external_interrupt_pending_flags)
    end
  endtask
  task automatic t_cnt();
    counter_mode_bits = 2'h1;
    {counter_array_run, counter_array_ext_select} = 2'b11;
    repeat (3) begin
      {counter_event_inputs, counter_array_external_clock} = 3'b000;
      step(4);
      {counter_event_inputs, counter_array_external_clock} = 3'b111;
      step(4);
    end
    step(6);
    `CHK("count 0", 16'h0003, timer_counts[0])
    `CHK("count 1", 16'h0000, timer_counts[1])
    `CHK("array count", 16'h0003, counter_array_count)
  endtask
  task automatic t_rpin();
    enter_idle = 1'b1;
    step(1);
    enter_idle = 1'b0;
    reset_pin = 1'b1;
    step(30);
    `CHK("wake", 1'b0, idle_active)
    `CHK("port level", PORT_RESET, high_port_pins.out)
    `CHK("short pulse", 1'b0, chip_reset)
    reset_pin = 1'b0;
    step(8);
    enter_powerdown = 1'b1;
    step(1);
    enter_powerdown = 1'b0;
    reset_pin = 1'b1;
    step(75);
    `CHK("full reset", 1'b1, chip_reset)
    `CHK("powerdown", 1'b0, powerdown_active)
    reset_pin = 1'b0;
    wrel();
  endtask
  task automatic t_ser();
    {serial_mode, serial_shift_clock, serial_rx_drive} = 4'b0011;
    step(2);
    `CHK("shift clock", 1'b1, transmit_data_out)
    `CHK("rx drive", 1'b1, receive_data_oe)
    `CHK("rx out", 1'b0, receive_data_out)
    `CHK("rx sync", 1'b1, serial_rx_data)
    for (int m = 1; m < 4; m++) begin
      serial_mode = m[1:0];
      serial_tx_data = m[0];
      step(2);
      `CHK("tx data", m[0], transmit_data_out)
      `CHK("rx drive", 1'b0, receive_data_oe)
    end
  endtask
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    {reset_pin, external_fetch_strap, page_mode, enter_idle} = 4'h4;
    {counter_array_external_clock, counter_array_run} = 2'h2;
    {counter_array_ext_select, fetch_range_bit_low, fetch_range_bit_high} = '0;
    {enter_powerdown, serial_shift_clock, serial_tx_data} = '0;
    {serial_rx_drive, receive_data_in, serial_mode} = 4'h4;
    {external_interrupt_inputs, counter_event_inputs} = 4'hF;
    {interrupt_edge_select_bits, interrupt_flag_clear, counter_mode_bits} = '0;
    bus_req = '0;
    reset = 1'b1;
    n_fail = 0;
    check_count = 0;
    step(12);
    `CHK("reset drive", OE_OFF, low_port_pins.oe)
    reset = 1'b0;
    wrel();
    t_fetch();
    t_range();
    t_bus();
    t_int();
    t_cnt();
    t_rpin();
    t_ser();
    stop_test();
  end
endmodule
